// File: acs_map.svh
// register offsets, field positions, reset values and timing counts for the scan/clock block
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_ADDR_W 4
`define ACS_OFF_SCAN_SELECT 4'h0
`define ACS_OFF_CONV_CTRL 4'h1
`define ACS_OFF_SCAN_STATUS 4'h2
`define ACS_SCAN_SELECT_RST 16'h0000
`define ACS_CONV_CTRL_RST 16'h0000
`define ACS_BIT_BAND_GAP 15
`define ACS_BIT_HALF_BAND_GAP 14
`define ACS_BIT_CORE_REGULATOR 13
`define ACS_PIN_SELECT_MSB 12
`define ACS_CTRL_START_BIT 15
`define ACS_CTRL_CONT_BIT 14
`define ACS_CTRL_DIV_MSB 7
`define ACS_CTRL_DIV_W 8
`define ACS_CHAN_W 4
`define ACS_CHAN_N 16
`define ACS_TCY_OSC_PERIODS 2
`define ACS_SAMPLE_TADS 4'h3
`define ACS_CONVERT_TADS 4'hC
`endif

// File: acs_pkg.sv
// types shared by the scan/clock block
package acs_pkg;
  typedef enum logic [1:0] {ACS_IDLE, ACS_FIND, ACS_SAMPLE, ACS_CONVERT} acs_state_e;
  typedef logic [3:0] acs_chan_t;
endpackage : acs_pkg

// File: acs_clk_div.sv
// conversion clock divider: one tick every (divider+1) instruction cycles
`timescale 1ns/1ns
`include "acs_map.svh"
module acs_clk_div (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [`ACS_CTRL_DIV_W-1:0] conv_clock_divider,
  output logic tad_tick
);
  logic [`ACS_CTRL_DIV_W-1:0] cnt_r;

  // count restarts whenever idle so the first period is full length
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      tad_tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      tad_tick <= 1'b0;
    end else if (cnt_r == conv_clock_divider) begin
      cnt_r <= '0;
      tad_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tad_tick <= 1'b0;
    end
  end
endmodule : acs_clk_div

// File: acs_next_chan.sv
// picks the next enabled channel after the current one, wrapping around
`timescale 1ns/1ns
`include "acs_map.svh"
module acs_next_chan (
  input wire logic [`ACS_CHAN_N-1:0] scan_select,
  input wire acs_pkg::acs_chan_t current,
  output acs_pkg::acs_chan_t next_chan,
  output logic found,
  output logic wrapped
);
  always_comb begin
    logic [4:0] idx;
    idx = '0;
    next_chan = current;
    found = 1'b0;
    wrapped = 1'b0;
    // search from current+1 through current, so lone channel repeats
    for (int i = 1; i <= `ACS_CHAN_N; i++) begin
      idx = 5'(current) + 5'(i);
      if (!found && scan_select[idx[3:0]]) begin
        found = 1'b1;
        next_chan = idx[3:0];
        wrapped = idx[4];
      end
    end
  end
endmodule : acs_next_chan

// File: acs_scan_ctrl.sv
// input scan select register, conversion clock divider and automatic scan sequencer
`timescale 1ns/1ns
`include "acs_map.svh"
module acs_scan_ctrl (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [`ACS_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic conv_done,
  output logic [3:0] mux_channel,
  output logic mux_sample,
  output logic conv_start,
  output logic scan_busy,
  output logic scan_pass_done
);
  logic [15:0] input_scan_select_r;
  logic [`ACS_CTRL_DIV_W-1:0] conv_clock_divider_r;
  logic cont_r;
  logic start_pulse;
  acs_pkg::acs_state_e state_r;
  acs_pkg::acs_chan_t chan_r;
  acs_pkg::acs_chan_t next_chan;
  logic found;
  logic wrapped;
  logic tad_tick;
  logic [3:0] tad_cnt_r;
  logic first_r;
  logic [15:0] scan_enables;

  // software view of the channel enables: band gap, half band gap, regulator, pins
  assign scan_enables = {input_scan_select_r[`ACS_BIT_BAND_GAP],
                         input_scan_select_r[`ACS_BIT_HALF_BAND_GAP],
                         input_scan_select_r[`ACS_BIT_CORE_REGULATOR],
                         input_scan_select_r[`ACS_PIN_SELECT_MSB:0]};

  assign start_pulse = reg_wr && reg_addr == `ACS_OFF_CONV_CTRL && reg_wdata[`ACS_CTRL_START_BIT];

  // registers: missing-pin bits are not forced clear, software owns them on small packages
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      input_scan_select_r <= `ACS_SCAN_SELECT_RST;
    end else if (reg_wr && reg_addr == `ACS_OFF_SCAN_SELECT) begin
      input_scan_select_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_clock_divider_r <= `ACS_CTRL_DIV_W'(`ACS_CONV_CTRL_RST);
      cont_r <= 1'b0;
    end else if (reg_wr && reg_addr == `ACS_OFF_CONV_CTRL) begin
      conv_clock_divider_r <= reg_wdata[`ACS_CTRL_DIV_MSB:0];
      cont_r <= reg_wdata[`ACS_CTRL_CONT_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ACS_OFF_SCAN_SELECT: reg_rdata <= input_scan_select_r;
        `ACS_OFF_CONV_CTRL: reg_rdata <= {1'b0, cont_r, 6'h00, conv_clock_divider_r};
        `ACS_OFF_SCAN_STATUS: reg_rdata <= {scan_busy, 11'h000, chan_r};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // sys_clk stands for the instruction cycle (two oscillator periods)
  acs_clk_div u_div (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .run(state_r == acs_pkg::ACS_SAMPLE || state_r == acs_pkg::ACS_CONVERT),
    .conv_clock_divider(conv_clock_divider_r),
    .tad_tick(tad_tick)
  );

  acs_next_chan u_next (
    .scan_select(scan_enables),
    .current(first_r ? 4'hF : chan_r),
    .next_chan(next_chan),
    .found(found),
    .wrapped(wrapped)
  );

  // sequencer: sample then convert each enabled channel, counting conversion clocks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= acs_pkg::ACS_IDLE;
      chan_r <= 4'h0;
      first_r <= 1'b1;
      tad_cnt_r <= 4'h0;
      scan_pass_done <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      scan_pass_done <= 1'b0;
      conv_start <= 1'b0;
      unique case (state_r)
        acs_pkg::ACS_IDLE: begin
          first_r <= 1'b1;
          if (start_pulse) begin
            state_r <= acs_pkg::ACS_FIND;
          end
        end
        acs_pkg::ACS_FIND: begin
          // a pass with nothing enabled ends at once
          if (!found) begin
            state_r <= acs_pkg::ACS_IDLE;
            scan_pass_done <= 1'b1;
          end else if (wrapped && !first_r) begin
            scan_pass_done <= 1'b1;
            state_r <= cont_r ? acs_pkg::ACS_SAMPLE : acs_pkg::ACS_IDLE;
            chan_r <= next_chan;
            tad_cnt_r <= 4'h0;
          end else begin
            state_r <= acs_pkg::ACS_SAMPLE;
            chan_r <= next_chan;
            first_r <= 1'b0;
            tad_cnt_r <= 4'h0;
          end
        end
        acs_pkg::ACS_SAMPLE: begin
          if (tad_tick) begin
            if (tad_cnt_r == `ACS_SAMPLE_TADS - 4'h1) begin
              tad_cnt_r <= 4'h0;
              state_r <= acs_pkg::ACS_CONVERT;
              conv_start <= 1'b1;
            end else begin
              tad_cnt_r <= tad_cnt_r + 4'h1;
            end
          end
        end
        acs_pkg::ACS_CONVERT: begin
          // conversion ends on the converter's flag or after the fixed clock count
          if (conv_done || (tad_tick && tad_cnt_r == `ACS_CONVERT_TADS - 4'h1)) begin
            tad_cnt_r <= 4'h0;
            state_r <= acs_pkg::ACS_FIND;
          end else if (tad_tick) begin
            tad_cnt_r <= tad_cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_channel <= 4'h0;
      mux_sample <= 1'b0;
      scan_busy <= 1'b0;
    end else begin
      mux_channel <= chan_r;
      mux_sample <= state_r == acs_pkg::ACS_SAMPLE;
      scan_busy <= state_r != acs_pkg::ACS_IDLE;
    end
  end
endmodule : acs_scan_ctrl

// File: acs_conv_model.sv
// converter partner: answers conversion starts and records the channels converted
`timescale 1ns/1ns
module acs_conv_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic conv_start,
  input wire logic [3:0] mux_channel,
  input wire logic slow,
  input wire logic clr,
  output logic conv_done,
  output logic [15:0] seen
);
  logic [3:0] sh_r;
  // slow leaves the end of conversion to the block's own fixed count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r <= 4'h0;
      conv_done <= 1'b0;
    end else begin
      sh_r <= {sh_r[2:0], conv_start};
      conv_done <= sh_r[3] & !slow;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) seen <= 16'h0000;
    else if (clr) seen <= 16'h0000;
    else if (conv_start) seen[mux_channel] <= 1'b1;
  end
endmodule : acs_conv_model

// File: acs_scan_ctrl_asserts.sv
// port checker for the scan/clock block
`timescale 1ns/1ns
module acs_scan_ctrl_asserts (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [3:0] mux_channel,
  input wire logic mux_sample,
  input wire logic conv_start
);
  logic [15:0] sel_r;
  logic [7:0] div_r;
  logic [11:0] cnt_r;
  logic [11:0] want;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_r <= 16'h0000;
      div_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 4'h0) sel_r <= reg_wdata;
      if (reg_addr == 4'h1) div_r <= reg_wdata[7:0];
    end
  end
  // holds the last window's length so a late start pulse still sees it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) cnt_r <= 12'h000;
    else if ($rose(mux_sample)) cnt_r <= 12'h001;
    else if (mux_sample) cnt_r <= cnt_r + 12'h001;
  end
  assign want = 12'h003 * ({4'h0, div_r} + 12'h001);
  scan_sel_a: assert property (conv_start |-> sel_r[mux_channel]) else $error("bad channel");
  half_gap_a: assert property (conv_start && mux_channel == 4'hE |-> sel_r[14]) else $error("half gap");
  core_reg_a: assert property (conv_start && mux_channel == 4'hD |-> sel_r[13]) else $error("core reg");
  band_gap_a: assert property (conv_start && mux_channel == 4'hF |-> sel_r[15]) else $error("band gap");
  tad_len_a: assert property (conv_start |-> cnt_r + 12'h002 >= want && cnt_r <= want + 12'h002)
    else $error("sample length");
  sample_min_a: assert property ($rose(mux_sample) |-> mux_sample [*3]) else $error("sample short");
endmodule : acs_scan_ctrl_asserts
bind acs_scan_ctrl acs_scan_ctrl_asserts i_chk (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .mux_channel, .mux_sample, .conv_start);

// File: acs_scan_ctrl_tb.sv
// self-checking bench for the scan/clock block
`timescale 1ns/1ns
module acs_scan_ctrl_tb;
  logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, clr = 1'b0;
  logic [3:0] reg_addr = 4'h0, mux_channel;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, seen;
  logic conv_done, mux_sample, conv_start, scan_busy, scan_pass_done;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  acs_scan_ctrl i_dut (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_done,
    .mux_channel, .mux_sample, .conv_start, .scan_busy, .scan_pass_done);
  acs_conv_model i_conv (.sys_clk, .arst_n, .conv_start, .mux_channel, .slow, .clr, .conv_done, .seen);
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(reg_rdata, exp);
  endtask : rd_chk
  // seen must equal the select word: every set channel at least once, no cleared one
  // a pass that never ends fails here rather than letting an empty select word slip through
  task automatic run(input logic [15:0] sel, ctl, input logic s);
    logic hit;
    hit = 1'b0;
    @(posedge sys_clk);
    clr <= 1'b1;
    slow <= s;
    wr(4'h0, sel);
    clr <= 1'b0;
    wr(4'h1, ctl);
    for (int i = 0; i < 3000 && scan_pass_done !== 1'b1; i++) begin
      @(posedge sys_clk);
      hit = hit | (scan_busy === 1'b1);
    end
    chk({15'h0000, scan_pass_done}, 16'h0001);
    chk(seen, sel);
    @(posedge sys_clk);
    // continuous mode keeps scanning after the pass, single mode goes idle
    chk({14'h0000, hit, scan_busy}, {14'h0000, 1'b1, ctl[14]});
  endtask : run
  task automatic wrap_up;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_chk(4'h0, 16'h0000);
    rd_chk(4'h3, 16'h0000);
    wr(4'h0, 16'hA5C3);
    rd_chk(4'h0, 16'hA5C3);
    run(16'hE005, 16'h8001, 1'b0);
    run(16'h0E3F, 16'h8000, 1'b1);
    run(16'h8000, 16'h8003, 1'b0);
    rd_chk(4'h1, 16'h0003);
    run(16'h0000, 16'h8002, 1'b0);
    run(16'h0003, 16'hC000, 1'b0);
    wr(4'h1, 16'h0000);
    repeat (100) @(posedge sys_clk);
    rd_chk(4'h2, 16'h0000);
    wrap_up();
  end
endmodule : acs_scan_ctrl_tb
